// File: logic/txsb_defines.vh
`ifndef TXSB_DEFINES_VH
`define TXSB_DEFINES_VH

// Bus geometry
`define TXSB_ADDR_W          14
`define TXSB_IDX_W           12

// Register indexes; byte address is four times the index
`define TXSB_IDX_FS_LO       12'h836
`define TXSB_IDX_FS_HI       12'h837
`define TXSB_IDX_GAP_FIRST   12'h838
`define TXSB_IDX_GAP_LAST    12'h83f
`define TXSB_IDX_REVISION    12'h840
`define TXSB_IDX_SCRATCH     12'h841
`define TXSB_IDX_IDENT0      12'h842
`define TXSB_IDX_IDENT1      12'h843
`define TXSB_IDX_IDENT2      12'h844
`define TXSB_IDX_CONTROL     12'h845
`define TXSB_IDX_CONDITION   12'h846
`define TXSB_IDX_IRQ_STATUS  12'h850
`define TXSB_IDX_IRQ_MASK    12'h851
`define TXSB_IDX_OCT_LO      12'h860
`define TXSB_IDX_OCT_HI      12'h861

// Reset values
`define TXSB_SCRATCH_RESET   32'h00000008
`define TXSB_MASK_RESET      3'h0

// Control register fields
`define TXSB_CTL_COUNT_CLR   0
`define TXSB_CTL_PERR_CLR    1
`define TXSB_CTL_SNAPSHOT    2

// Condition register fields
`define TXSB_COND_PERR       0
`define TXSB_COND_PAUSED     1

// Interrupt status and mask fields
`define TXSB_IRQ_W           3
`define TXSB_IRQ_PERR        0
`define TXSB_IRQ_FS_WRAP     1
`define TXSB_IRQ_OCT_WRAP    2

// Bus responses
`define TXSB_RESP_OKAY       2'h0
`define TXSB_RESP_SLVERR     2'h2

`endif

// File: logic/txsb_counter64.v
`timescale 1ns/10ps
`default_nettype none

module txsb_counter64 (
  // Clock and reset
  input  wire        clk_in,
  input  wire        resetn_in,
  // Control
  input  wire        clear_in,
  input  wire        freeze_in,
  // Increment
  input  wire        inc_valid_in,
  input  wire [15:0] inc_amount_in,
  // Results
  output wire [63:0] visible_out,
  output reg         parity_err_out,
  output reg         wrap_out
);

  reg  [63:0] count;
  reg  [63:0] snap;
  reg         parity;
  wire [64:0] sum;

  assign sum = {1'b0, count} + {49'h0, inc_amount_in};

  // Live counter; clear beats a coincident increment
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count    <= 64'h0;
      parity   <= 1'b0;
      wrap_out <= 1'b0;
    end else if (clear_in) begin
      count    <= 64'h0;
      parity   <= 1'b0;
      wrap_out <= 1'b0;
    end else if (inc_valid_in) begin
      count    <= sum[63:0];
      parity   <= ^sum[63:0];
      wrap_out <= sum[64];
    end else begin
      wrap_out <= 1'b0;
    end
  end

  // Parity check catches upsets in the stored count
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      parity_err_out <= 1'b0;
    end else begin
      parity_err_out <= (^count) != parity;
    end
  end

  // Snapshot follows the count until frozen
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      snap <= 64'h0;
    end else if (clear_in) begin
      snap <= 64'h0;
    end else if (!freeze_in) begin
      snap <= count;
    end
  end

  assign visible_out = freeze_in ? snap : count;

endmodule

`default_nettype wire

// File: logic/txsb_top.v
// Summary of operation
// R1 - A 64-bit frame-start count is readable as low and high read-only words.
// R2 - A read-only word returns the statistics module revision.
// R3 - A scratch word keeps what software writes and resets to 0x08.
// R4 - Three read-only words return a twelve-character identifier, first characters lowest.
// R5 - While control bit 2 is one, reads show counts frozen at that moment while counting goes on.
// R6 - Writing one to control bit 1 clears the parity flag and the bit then drops by itself.
// R7 - Writing one to control bit 0 zeroes every counter together and the bit drops by itself.
// R8 - Control bits 31 to 3 are reserved and do nothing.
// R9 - Condition bit 1 is high exactly while the snapshot bit is set.
// R10 - Condition bit 0 latches any counter parity error until cleared; bits 31 to 2 are reserved.
// R11 - A 64-bit count of good payload bytes is readable as low and high words.
// R12 - Each cycle the increment strobe is high, the 16-bit byte increment is added to that count.
// R13 - The reserved gap before the revision word reads zero and ignores writes.
// R14 - Reading a counter leaves it unchanged and writes to counter words are ignored.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "txsb_defines.vh"

module txsb_top #(
  // Arbitrary neutral values
  parameter [31:0] REVISION_ID = 32'h00000001,
  parameter [31:0] IDENT_WORD0 = 32'h54585342,
  parameter [31:0] IDENT_WORD1 = 32'h414e4b5f,
  parameter [31:0] IDENT_WORD2 = 32'h53544154
) (
  // Clock and reset
  input  wire                      core_clk_in,
  input  wire                      resetn_in,
  // AXI4-Lite write address
  input  wire [`TXSB_ADDR_W-1:0]   s_axi_awaddr_in,
  input  wire                      s_axi_awvalid_in,
  output reg                       s_axi_awready_out,
  // AXI4-Lite write data
  input  wire [31:0]               s_axi_wdata_in,
  input  wire [3:0]                s_axi_wstrb_in,
  input  wire                      s_axi_wvalid_in,
  output reg                       s_axi_wready_out,
  // AXI4-Lite write response
  output reg  [1:0]                s_axi_bresp_out,
  output reg                       s_axi_bvalid_out,
  input  wire                      s_axi_bready_in,
  // AXI4-Lite read address
  input  wire [`TXSB_ADDR_W-1:0]   s_axi_araddr_in,
  input  wire                      s_axi_arvalid_in,
  output reg                       s_axi_arready_out,
  // AXI4-Lite read data
  output reg  [31:0]               s_axi_rdata_out,
  output reg  [1:0]                s_axi_rresp_out,
  output reg                       s_axi_rvalid_out,
  input  wire                      s_axi_rready_in,
  // Transmit path statistics events
  input  wire                      frame_start_strobe_in,
  input  wire [15:0]               good_payload_byte_increment_in,
  input  wire                      good_payload_increment_strobe_in,
  // Interrupt
  output reg                       irq_out
);

  // Word index of a byte address
  function [`TXSB_IDX_W-1:0] word_index;
    input [`TXSB_ADDR_W-1:0] addr;
    begin
      word_index = addr[`TXSB_ADDR_W-1:2];
    end
  endfunction

  // Byte-lane merge of write data into an old value
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Write channel holding registers
  reg  [`TXSB_ADDR_W-1:0]  wr_addr;
  reg  [31:0]              wr_data;
  reg  [3:0]               wr_strb;
  reg                      aw_held;
  reg                      w_held;
  wire                     wr_fire;
  wire [`TXSB_IDX_W-1:0]   wr_idx;
  wire [31:0]              wr_bits;
  wire [`TXSB_IDX_W-1:0]   rd_idx;

  // Software registers
  reg  [31:0]              scratch_word;
  reg                      ctl_snapshot;
  reg                      ctl_perr_clr;
  reg                      ctl_count_clr;
  reg                      parity_flag;
  reg  [`TXSB_IRQ_W-1:0]   irq_status;
  reg  [`TXSB_IRQ_W-1:0]   irq_mask;

  // Counter results
  wire [63:0]              fs_visible;
  wire [63:0]              oct_visible;
  wire                     fs_perr;
  wire                     oct_perr;
  wire                     fs_wrap;
  wire                     oct_wrap;
  wire [`TXSB_IRQ_W-1:0]   irq_events;
  wire [`TXSB_IRQ_W-1:0]   irq_w1c;
  wire [`TXSB_IRQ_W-1:0]   next_irq_status;

  // Read path next values
  reg  [31:0]              next_rdata;
  reg  [1:0]               next_rresp;
  reg                      next_wresp_err;

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid_out;
  assign wr_idx  = word_index(wr_addr);
  assign rd_idx  = word_index(s_axi_araddr_in);
  // Only written lanes can set or clear bits
  assign wr_bits = lane_merge(32'h0, wr_data, wr_strb);

  // Frame-start counter, one per strobe
  txsb_counter64 u_frame_start (
    .clk_in         (core_clk_in),
    .resetn_in      (resetn_in),
    .clear_in       (ctl_count_clr),                  // R7
    .freeze_in      (ctl_snapshot),                   // R5
    .inc_valid_in   (frame_start_strobe_in),          // R1
    .inc_amount_in  (16'h0001),
    .visible_out    (fs_visible),
    .parity_err_out (fs_perr),
    .wrap_out       (fs_wrap)
  );

  // Good payload octet counter
  txsb_counter64 u_good_octets (
    .clk_in         (core_clk_in),
    .resetn_in      (resetn_in),
    .clear_in       (ctl_count_clr),                  // R7
    .freeze_in      (ctl_snapshot),                   // R5
    .inc_valid_in   (good_payload_increment_strobe_in), // R12
    .inc_amount_in  (good_payload_byte_increment_in), // R11
    .visible_out    (oct_visible),
    .parity_err_out (oct_perr),
    .wrap_out       (oct_wrap)
  );

  // Write address and data accepted in either order
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      wr_addr           <= {`TXSB_ADDR_W{1'b0}};
      wr_data           <= 32'h0;
      wr_strb           <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        s_axi_awready_out <= 1'b0;
        aw_held           <= 1'b1;
        wr_addr           <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        s_axi_wready_out <= 1'b0;
        w_held           <= 1'b1;
        wr_data          <= s_axi_wdata_in;
        wr_strb          <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      // Reopen both channels only once the response is taken
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Write response classification
  always @* begin
    next_wresp_err = 1'b0;
    case (wr_idx)
      `TXSB_IDX_FS_LO, `TXSB_IDX_FS_HI,
      `TXSB_IDX_REVISION, `TXSB_IDX_SCRATCH,
      `TXSB_IDX_IDENT0, `TXSB_IDX_IDENT1, `TXSB_IDX_IDENT2,
      `TXSB_IDX_CONTROL, `TXSB_IDX_CONDITION,
      `TXSB_IDX_IRQ_STATUS, `TXSB_IDX_IRQ_MASK,
      `TXSB_IDX_OCT_LO, `TXSB_IDX_OCT_HI: begin
        next_wresp_err = 1'b0;                        // R14
      end
      default: begin
        // Gap words answer OKAY and drop the data
        next_wresp_err = !((wr_idx >= `TXSB_IDX_GAP_FIRST) &&
                           (wr_idx <= `TXSB_IDX_GAP_LAST)); // R13
      end
    endcase
  end

  // Write response, one cycle after both halves are held
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `TXSB_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= next_wresp_err ? `TXSB_RESP_SLVERR : `TXSB_RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Scratch word
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scratch_word <= `TXSB_SCRATCH_RESET;            // R3
    end else if (wr_fire && (wr_idx == `TXSB_IDX_SCRATCH)) begin
      scratch_word <= lane_merge(scratch_word, wr_data, wr_strb); // R3
    end
  end

  // Control bits; upper bits are not stored
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_snapshot  <= 1'b0;
      ctl_perr_clr  <= 1'b0;
      ctl_count_clr <= 1'b0;
    end else begin
      // Action bits live for a single cycle
      ctl_perr_clr  <= 1'b0;                          // R6
      ctl_count_clr <= 1'b0;                          // R7
      if (wr_fire && (wr_idx == `TXSB_IDX_CONTROL) && wr_strb[0]) begin
        ctl_snapshot  <= wr_data[`TXSB_CTL_SNAPSHOT]; // R5
        ctl_perr_clr  <= wr_data[`TXSB_CTL_PERR_CLR]; // R6
        ctl_count_clr <= wr_data[`TXSB_CTL_COUNT_CLR]; // R7
      end
    end
  end

  // Parity flag; a new error beats a clear in the same cycle
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      parity_flag <= 1'b0;
    end else if (fs_perr || oct_perr) begin
      parity_flag <= 1'b1;                            // R10
    end else if (ctl_perr_clr) begin
      parity_flag <= 1'b0;                            // R6
    end
  end

  // Interrupt events and write-one-to-clear
  assign irq_events = {oct_wrap, fs_wrap, (fs_perr | oct_perr)};
  assign irq_w1c = (wr_fire && (wr_idx == `TXSB_IDX_IRQ_STATUS)) ?
                   wr_bits[`TXSB_IRQ_W-1:0] : {`TXSB_IRQ_W{1'b0}};
  assign next_irq_status = (irq_status & ~irq_w1c) | irq_events;

  // Sticky status, mask and registered interrupt line
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status <= {`TXSB_IRQ_W{1'b0}};
      irq_mask   <= `TXSB_MASK_RESET;
      irq_out    <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_fire && (wr_idx == `TXSB_IDX_IRQ_MASK)) begin
        irq_mask <= wr_bits[`TXSB_IRQ_W-1:0] |
                    (irq_mask & ~{`TXSB_IRQ_W{wr_strb[0]}});
      end
      // One cycle behind the status it reflects
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // Read data decode; reads never touch counter state
  always @* begin
    next_rdata = 32'h0;
    next_rresp = `TXSB_RESP_OKAY;
    case (rd_idx)
      `TXSB_IDX_FS_LO: begin
        next_rdata = fs_visible[31:0];                // R1
      end
      `TXSB_IDX_FS_HI: begin
        next_rdata = fs_visible[63:32];               // R1
      end
      `TXSB_IDX_REVISION: begin
        next_rdata = REVISION_ID;                     // R2
      end
      `TXSB_IDX_SCRATCH: begin
        next_rdata = scratch_word;                    // R3
      end
      `TXSB_IDX_IDENT0: begin
        next_rdata = IDENT_WORD0;                     // R4
      end
      `TXSB_IDX_IDENT1: begin
        next_rdata = IDENT_WORD1;                     // R4
      end
      `TXSB_IDX_IDENT2: begin
        next_rdata = IDENT_WORD2;                     // R4
      end
      `TXSB_IDX_CONTROL: begin
        // Reserved control bits read zero
        next_rdata[`TXSB_CTL_SNAPSHOT]  = ctl_snapshot;  // R8
        next_rdata[`TXSB_CTL_PERR_CLR]  = ctl_perr_clr;
        next_rdata[`TXSB_CTL_COUNT_CLR] = ctl_count_clr;
      end
      `TXSB_IDX_CONDITION: begin
        next_rdata[`TXSB_COND_PAUSED] = ctl_snapshot; // R9
        next_rdata[`TXSB_COND_PERR]   = parity_flag;  // R10
      end
      `TXSB_IDX_IRQ_STATUS: begin
        next_rdata[`TXSB_IRQ_W-1:0] = irq_status;
      end
      `TXSB_IDX_IRQ_MASK: begin
        next_rdata[`TXSB_IRQ_W-1:0] = irq_mask;
      end
      `TXSB_IDX_OCT_LO: begin
        next_rdata = oct_visible[31:0];               // R11
      end
      `TXSB_IDX_OCT_HI: begin
        next_rdata = oct_visible[63:32];              // R11
      end
      default: begin
        if ((rd_idx >= `TXSB_IDX_GAP_FIRST) && (rd_idx <= `TXSB_IDX_GAP_LAST)) begin
          next_rdata = 32'h0;                         // R13
        end else begin
          next_rresp = `TXSB_RESP_SLVERR;
        end
      end
    endcase
  end

  // Read channel; one read in flight, data one cycle after the address
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= `TXSB_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= next_rdata;                // R14
      s_axi_rresp_out   <= next_rresp;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: bench/txsb_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "txsb_defines.vh"

module txsb_asserts #(
  parameter [31:0] REVISION_ID = 32'h00000001
) (
  // Clock and reset
  input wire logic                    core_clk_in,
  input wire logic                    resetn_in,
  // Write channels
  input wire logic                    s_axi_awvalid_in,
  input wire logic                    s_axi_awready_out,
  input wire logic                    s_axi_wvalid_in,
  input wire logic                    s_axi_wready_out,
  input wire logic [1:0]              s_axi_bresp_out,
  input wire logic                    s_axi_bvalid_out,
  input wire logic                    s_axi_bready_in,
  // Read channels
  input wire logic [`TXSB_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic                    s_axi_arvalid_in,
  input wire logic                    s_axi_arready_out,
  input wire logic [31:0]             s_axi_rdata_out,
  input wire logic [1:0]              s_axi_rresp_out,
  input wire logic                    s_axi_rvalid_out,
  input wire logic                    s_axi_rready_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // Word index and acceptance of a read request and of a write request
  wire logic [11:0] rd_idx;
  wire logic        rd_take;
  wire logic        wr_take;
  assign rd_idx  = s_axi_araddr_in[13:2];
  assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_take = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;

  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer not one cycle after request");
  chk_wr_answer: assert property (wr_take |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write answer not two cycles after request");
  chk_b_blocks: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  chk_r_blocks: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  chk_ready_back: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
    s_axi_awready_out && s_axi_wready_out && !s_axi_bvalid_out)
    else $error("write channels not reopened after response");
  chk_gap_zero: assert property (rd_take && rd_idx >= `TXSB_IDX_GAP_FIRST &&
    rd_idx <= `TXSB_IDX_GAP_LAST |=> s_axi_rdata_out == 32'h0 && s_axi_rresp_out == 2'h0)
    else $error("reserved gap read not zero with okay");
  chk_rev_word: assert property (rd_take && rd_idx == `TXSB_IDX_REVISION |=>
    s_axi_rdata_out == REVISION_ID)
    else $error("revision word wrong");
  chk_unmapped_err: assert property (rd_take && rd_idx == 12'hfff |=>
    s_axi_rresp_out == `TXSB_RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
endmodule

`default_nettype wire

// File: bench/txsb_tx_model.sv
`timescale 1ns/10ps
`default_nettype none

module txsb_tx_model (
  // Clock and reset
  input wire logic         core_clk_in,
  input wire logic         resetn_in,
  // Traffic control from the bench
  input wire logic         run_in,
  input wire logic         slow_in,
  input wire logic [15:0]  step_in,
  // Statistics events towards the block
  output var logic         frame_start_strobe_out,
  output var logic [15:0]  byte_increment_out,
  output var logic         increment_strobe_out,
  // Totals sent, for expectations
  output var logic [63:0]  frames_sent_out,
  output var logic [63:0]  bytes_sent_out
);
  logic phase;

  // One frame and one increment per beat; slow mode sends every other cycle
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase <= 1'b0;
      frame_start_strobe_out <= 1'b0;
      byte_increment_out <= 16'h5a5a;
      increment_strobe_out <= 1'b0;
      frames_sent_out <= 64'h0;
      bytes_sent_out <= 64'h0;
    end else begin
      phase <= ~phase;
      if (run_in && (!slow_in || phase)) begin
        frame_start_strobe_out <= 1'b1;
        byte_increment_out <= step_in;
        increment_strobe_out <= 1'b1;
        frames_sent_out <= frames_sent_out + 64'h1;
        bytes_sent_out <= bytes_sent_out + {48'h0, step_in};
      end else begin
        frame_start_strobe_out <= 1'b0;
        // Idle value must not look like a held amount
        byte_increment_out <= ~byte_increment_out;
        increment_strobe_out <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "txsb_defines.vh"

module tb_top;
  // Arbitrary identity values
  localparam [31:0] REV = 32'h000000a3;
  localparam [31:0] ID0 = 32'h74657374;
  localparam [31:0] ID1 = 32'h5f626e6b;
  localparam [31:0] ID2 = 32'h5f737461;

  logic        core_clk_in;
  logic        resetn_in;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic        awvalid, wvalid, bready, arvalid, rready, run, slow;
  logic [15:0] step;
  logic [1:0]  r;
  logic [63:0] fb, ob, f0, o0;
  wire         awready, wready, bvalid, arready, rvalid, irq, fs, istb;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] inc;
  wire  [63:0] frames, bytes;
  int          num_errors, num_checks;

  txsb_top #(.REVISION_ID(REV), .IDENT_WORD0(ID0), .IDENT_WORD1(ID1), .IDENT_WORD2(ID2)) i_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .frame_start_strobe_in(fs),
    .good_payload_byte_increment_in(inc), .good_payload_increment_strobe_in(istb),
    .irq_out(irq));

  txsb_tx_model i_tx (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .run_in(run), .slow_in(slow),
    .step_in(step), .frame_start_strobe_out(fs), .byte_increment_out(inc),
    .increment_strobe_out(istb), .frames_sent_out(frames), .bytes_sent_out(bytes));

  // Clock
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  task check(input string name, input [31:0] seen, input [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Address and data offered together, response awaited under a bound
  task wr(input [11:0] idx, input [31:0] data, output [1:0] resp);
    int n;
    n = 0;
    @(posedge core_clk_in);
    awaddr <= {idx, 2'b00};
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 40) num_errors++;
  endtask

  task rd(input [11:0] idx, output [31:0] data, output [1:0] resp);
    int n;
    n = 0;
    @(posedge core_clk_in);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 40) num_errors++;
  endtask

  task rdc(input string name, input [11:0] idx, input [31:0] exp);
    rd(idx, d, r);
    check(name, d, exp);
    check({name, " resp"}, {30'h0, r}, 32'h0);
  endtask

  // Low word then high word of a 64-bit count
  task chk64(input string name, input [11:0] lo, input [63:0] exp);
    rdc(name, lo, exp[31:0]);
    rdc(name, lo + 12'h1, exp[63:32]);
  endtask

  // Traffic burst, then let the last increments land
  task run_for(input int n, input logic s);
    slow <= s;
    run <= 1'b1;
    repeat (n) @(posedge core_clk_in);
    run <= 1'b0;
    repeat (4) @(posedge core_clk_in);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the longest traffic burst
  initial begin
    repeat (90000) @(posedge core_clk_in);
    num_errors++;
    complete_run;
  end

  initial begin
    resetn_in = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {run, slow, step} = '0;
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    // Reset values and fixed words
    rdc("scratch", `TXSB_IDX_SCRATCH, 32'h00000008);
    rdc("revision", `TXSB_IDX_REVISION, REV);
    rdc("ident0", `TXSB_IDX_IDENT0, ID0);
    rdc("ident1", `TXSB_IDX_IDENT1, ID1);
    rdc("ident2", `TXSB_IDX_IDENT2, ID2);
    rdc("condition", `TXSB_IDX_CONDITION, 32'h0);
    chk64("frames", `TXSB_IDX_FS_LO, 64'h0);
    // Scratch keeps its value; gap and unmapped words
    wr(`TXSB_IDX_SCRATCH, 32'hc3a55a3c, r);
    rdc("scratch", `TXSB_IDX_SCRATCH, 32'hc3a55a3c);
    wr(`TXSB_IDX_GAP_FIRST, 32'hffffffff, r);
    check("gap resp", {30'h0, r}, 32'h0);
    rdc("gap first", `TXSB_IDX_GAP_FIRST, 32'h0);
    rdc("gap last", `TXSB_IDX_GAP_LAST, 32'h0);
    rd(12'hfff, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, `TXSB_RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    // Fast then slow traffic
    step <= 16'h1234;
    run_for(25, 1'b0);
    step <= 16'h0fe1;
    run_for(30, 1'b1);
    chk64("frames", `TXSB_IDX_FS_LO, frames);
    chk64("octets", `TXSB_IDX_OCT_LO, bytes);
    wr(`TXSB_IDX_OCT_LO, 32'h0, r);
    wr(`TXSB_IDX_FS_HI, 32'hffffffff, r);
    check("ro write resp", {30'h0, r}, 32'h0);
    chk64("octets again", `TXSB_IDX_OCT_LO, bytes);
    chk64("frames again", `TXSB_IDX_FS_LO, frames);
    // Snapshot freezes reads while counting goes on
    f0 = frames;
    o0 = bytes;
    wr(`TXSB_IDX_CONTROL, 32'h4, r);
    rdc("paused", `TXSB_IDX_CONDITION, 32'h2);
    run_for(40, 1'b0);
    chk64("frozen frames", `TXSB_IDX_FS_LO, f0);
    chk64("frozen octets", `TXSB_IDX_OCT_LO, o0);
    wr(`TXSB_IDX_CONTROL, 32'h0, r);
    rdc("released", `TXSB_IDX_CONDITION, 32'h0);
    chk64("live octets", `TXSB_IDX_OCT_LO, bytes);
    // Reserved control bits do nothing
    wr(`TXSB_IDX_CONTROL, 32'hfffffff8, r);
    rdc("reserved cond", `TXSB_IDX_CONDITION, 32'h0);
    chk64("reserved octets", `TXSB_IDX_OCT_LO, bytes);
    // Parity clear and counter clear drop by themselves
    wr(`TXSB_IDX_CONTROL, 32'h2, r);
    rdc("perr clear bit", `TXSB_IDX_CONTROL, 32'h0);
    rdc("perr flag", `TXSB_IDX_CONDITION, 32'h0);
    wr(`TXSB_IDX_CONTROL, 32'h1, r);
    fb = frames;
    ob = bytes;
    rdc("clear bit", `TXSB_IDX_CONTROL, 32'h0);
    chk64("cleared frames", `TXSB_IDX_FS_LO, 64'h0);
    chk64("cleared octets", `TXSB_IDX_OCT_LO, 64'h0);
    // Long burst carries the octet count into the high word
    step <= 16'hffff;
    run_for(65540, 1'b0);
    chk64("carry octets", `TXSB_IDX_OCT_LO, bytes - ob);
    chk64("carry frames", `TXSB_IDX_FS_LO, frames - fb);
    // Wrap events cannot be reached here, so only mask and clear paths
    wr(`TXSB_IDX_IRQ_MASK, 32'h7, r);
    rdc("irq mask", `TXSB_IDX_IRQ_MASK, 32'h7);
    wr(`TXSB_IDX_IRQ_STATUS, 32'h7, r);
    rdc("irq status", `TXSB_IDX_IRQ_STATUS, 32'h0);
    check("irq line", {31'h0, irq}, 32'h0);
    complete_run;
  end
endmodule

bind txsb_top txsb_asserts #(.REVISION_ID(REVISION_ID)) i_chk (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in));

`default_nettype wire
